// ==== common/btx_pkg.sv ====
// btx_pkg: opcodes, operand codes, state counts and enums of the byte transfer unit.
// assumes one instruction state per core_clk cycle.
package btx_pkg;
   // ------------------------------------------------------------
   // opcodes
   // ------------------------------------------------------------
   localparam logic [4:0] OP5_MOV_A_R = 5'h01;
   localparam logic [4:0] OP5_MVI     = 5'h0d;
   localparam logic [5:0] OP6_IMM_TO_PAIR_MEM    = 6'h12;
   localparam logic [3:0] OP4_ACC_TO_PAIR_MEM    = 4'h7;
   localparam logic [7:0] OP_SR_W     = 8'h4d;
   localparam logic [7:0] OP_SR_R     = 8'h4c;
   localparam logic [7:0] OP_MVI_SR   = 8'h64;
   localparam logic [7:0] OP_DIR      = 8'h70;
   localparam logic [7:0] OP_IMM_TO_PAGE_SLOT     = 8'h71;
   localparam logic [7:0] OP_ACC_TO_PAGE_SLOT     = 8'h63;
   localparam logic [7:0] OP_PAGE_SLOT_TO_ACC     = 8'h01;
   localparam logic [4:0] DIR_LD5     = 5'h0d;
   localparam logic [4:0] DIR_ST5     = 5'h0f;
   localparam logic [1:0] SR_PFX      = 2'h3;
   // ------------------------------------------------------------
   // register file indices and pair store modes
   // ------------------------------------------------------------
   localparam logic [2:0] R_V = 3'h0;
   localparam logic [2:0] R_A = 3'h1;
   localparam logic [2:0] R_B = 3'h2;
   localparam logic [2:0] R_C = 3'h3;
   localparam logic [2:0] R_D = 3'h4;
   localparam logic [2:0] R_H = 3'h6;
   localparam logic [2:0] R_L = 3'h7;
   localparam logic [2:0] T_EAH = 3'h0;
   localparam logic [2:0] T_EAL = 3'h1;
   localparam logic [3:0] M_BC = 4'h1;
   localparam logic [3:0] M_DEI = 4'h4;
   localparam logic [3:0] M_HLD = 4'h7;
   localparam logic [3:0] M_DEB = 4'hb;
   localparam logic [3:0] M_HLA = 4'hc;
   localparam logic [3:0] M_HLB = 4'hd;
   localparam logic [3:0] M_HLEA = 4'he;
   localparam logic [3:0] M_HLBY = 4'hf;
   // ------------------------------------------------------------
   // state counts: executed / skipped
   // ------------------------------------------------------------
   localparam logic [4:0] ST_ONE = 5'd4;
   localparam logic [4:0] ST_SR = 5'd10;
   localparam logic [4:0] SK_TWO = 5'd7;
   localparam logic [4:0] ST_DIR = 5'd17;
   localparam logic [4:0] SK_DIR = 5'd14;
   localparam logic [4:0] ST_MVI = 5'd7;
   localparam logic [4:0] ST_MVI_SR = 5'd14;
   localparam logic [4:0] SK_MVI_SR = 5'd11;
   localparam logic [4:0] ST_IMM_TO_PAGE_SLOT = 5'd13;
   localparam logic [4:0] SK_IMM_TO_PAGE_SLOT = 5'd10;
   localparam logic [4:0] ST_ACC_TO_PAIR_MEM_S = 5'd7;
   localparam logic [4:0] ST_ACC_TO_PAIR_MEM_L = 5'd13;
   localparam logic [15:0] RESET_PC = 16'h0000;
   typedef enum logic [2:0] {
      PH_FETCH = 3'b000, PH_ISSUE = 3'b001, PH_WRITE = 3'b011,
      PH_RESULT = 3'b010, PH_HOLD = 3'b110
   } btx_phase_e;
   typedef enum logic [3:0] {
      K_MOV_A_R, K_SR_W, K_SR_R, K_DIR, K_MVI, K_MVI_SR,
      K_IMM_TO_PAGE_SLOT, K_IMM_TO_PAIR_MEM, K_ACC_TO_PAGE_SLOT, K_PAGE_SLOT_TO_ACC, K_ACC_TO_PAIR_MEM, K_BAD
   } btx_kind_e;
endpackage

// ==== verilog/btx_exec.sv ====
// btx_exec: fetch, decode and execute of the 8-bit transfer group.
// assumes synchronous program, data and special memories: data one cycle after address.
`timescale 1ns/1ns
module btx_exec #(
   parameter int ADDR_W = 16
) (
   input  wire logic                core_clk,
   input  wire logic                rst,
   output logic [15:0]              prog_addr,
   input  wire logic [7:0]          prog_data,
   output logic [15:0]              mem_addr,
   output logic [7:0]               mem_wdata,
   output logic                     mem_we,
   output logic                     mem_re,
   input  wire logic [7:0]          mem_rdata,
   output logic [5:0]               sfr_code,
   output logic [7:0]               sfr_wdata,
   output logic                     sfr_we,
   output logic                     sfr_re,
   input  wire logic [7:0]          sfr_rdata,
   input  wire logic                skip_set,
   input  wire logic                ea_wr_en,
   input  wire logic [15:0]         ea_wr_data,
   output logic [7:0][7:0]          gpr,
   output logic [15:0]              wide_accumulator,
   output logic                     instr_bypass_flag,
   output logic                     acc_chain_flag,
   output logic                     low_reg_chain_flag,
   output logic                     instr_done,
   output logic                     bad_op
);
   import btx_pkg::*;

   if (ADDR_W != 16) begin : g_chk
      $error("btx_exec serves a 16-bit address only");
   end

   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   function automatic btx_kind_e kind_of(input logic [7:0] op);
      logic [3:0] m;
      m = {op[7], op[2:0]};
      if (op[7:3] == OP5_MOV_A_R) return K_MOV_A_R;
      if (op[7:3] == OP5_MVI) return K_MVI;
      if (op[7:2] == OP6_IMM_TO_PAIR_MEM && op[1:0] != 2'h0) return K_IMM_TO_PAIR_MEM;
      if (op[6:3] == OP4_ACC_TO_PAIR_MEM && (m inside {[M_BC:M_HLD], [M_DEB:M_HLBY]})) return K_ACC_TO_PAIR_MEM;
      case (op)
         OP_SR_W:   return K_SR_W;
         OP_SR_R:   return K_SR_R;
         OP_MVI_SR: return K_MVI_SR;
         OP_DIR:    return K_DIR;
         OP_IMM_TO_PAGE_SLOT:   return K_IMM_TO_PAGE_SLOT;
         OP_ACC_TO_PAGE_SLOT:   return K_ACC_TO_PAGE_SLOT;
         OP_PAGE_SLOT_TO_ACC:   return K_PAGE_SLOT_TO_ACC;
         default:   return K_BAD;
      endcase
   endfunction

   // {length, executed states, skipped states}
   function automatic logic [12:0] shape(input btx_kind_e k, input logic [3:0] m);
      logic two;
      two = (m == M_DEB) || (m == M_HLBY);
      case (k)
         K_SR_W, K_SR_R: return {3'd2, ST_SR, SK_TWO};
         K_DIR:          return {3'd4, ST_DIR, SK_DIR};
         K_MVI:          return {3'd2, ST_MVI, ST_MVI};
         K_MVI_SR:       return {3'd3, ST_MVI_SR, SK_MVI_SR};
         K_IMM_TO_PAGE_SLOT:         return {3'd3, ST_IMM_TO_PAGE_SLOT, SK_IMM_TO_PAGE_SLOT};
         K_IMM_TO_PAIR_MEM, K_ACC_TO_PAGE_SLOT, K_PAGE_SLOT_TO_ACC: return {3'd2, ST_SR, SK_TWO};
         K_ACC_TO_PAIR_MEM: return {two ? 3'd2 : 3'd1, m[3] ? ST_ACC_TO_PAIR_MEM_L : ST_ACC_TO_PAIR_MEM_S,
                         two ? SK_TWO : ST_ONE};
         default:        return {3'd1, ST_ONE, ST_ONE};
      endcase
   endfunction

   function automatic logic [15:0] pair(input logic [7:0] r [8], input logic [2:0] hi);
      return {r[hi], r[hi + 3'd1]};
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   btx_phase_e  ph_q, ph_d;
   logic [4:0]  cnt_q;
   logic [15:0] pc_q, fetch_q;
   logic [7:0]  byte_q [4];
   logic [7:0]  regs_q [8];
   logic [15:0] ea_q;
   logic        skip_run_q, sk_q, l1_q, l0_q, done_q, bad_q;
   logic [15:0] maddr_q;
   logic [7:0]  mwdata_q, swdata_q;
   logic [5:0]  scode_q;
   logic        mwe_q, mre_q, swe_q, sre_q;

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   wire [7:0]  op0 = (cnt_q == 5'd1) ? prog_data : byte_q[0];
   wire [7:0]  b1 = byte_q[1];
   wire [7:0]  b2 = byte_q[2];
   wire [7:0]  b3 = byte_q[3];
   wire btx_kind_e kind = kind_of(op0);
   wire [3:0]  mode = {op0[7], op0[2:0]};
   wire [12:0] shp = shape(kind, mode);
   wire [2:0]  len = shp[12:10];
   wire [4:0]  tot = skip_run_q ? shp[4:0] : shp[9:5];
   wire        fin = (ph_q != PH_FETCH) && (cnt_q == tot - 5'd1);
   wire        run = !skip_run_q;
   wire        issue = (ph_q == PH_ISSUE) && run;

   wire [5:0]  sr_code = b1[5:0];
   wire        sr_pfx = (b1[7:6] == SR_PFX);
   wire        ok_w = sr_pfx && (sr_code inside
                  {[6'h00:6'h03], [6'h05:6'h0d], [6'h10:6'h14], 6'h17, 6'h18,
                   6'h1a, 6'h1b, 6'h28});
   wire        ok_r = sr_pfx && (sr_code inside
                  {[6'h00:6'h03], [6'h05:6'h09], 6'h0b, 6'h0d, 6'h19,
                   [6'h20:6'h23]});
   wire [3:0]  imm_code = {b1[7], b1[2:0]};
   wire        ok_i = (b1[6:3] == 4'h0) && (imm_code inside
                  {[4'h0:4'h3], [4'h5:4'h9], 4'hb, 4'hd});
   wire        dir_ld = (b1[7:3] == DIR_LD5);
   wire        dir_st = (b1[7:3] == DIR_ST5);
   wire [2:0]  dir_r = b1[2:0];

   wire        sr_w_go = (kind == K_SR_W) && ok_w;
   wire        sr_r_go = (kind == K_SR_R) && ok_r;
   wire        sr_i_go = (kind == K_MVI_SR) && ok_i;
   wire        ld_go = (kind == K_DIR) && dir_ld;
   wire        st_go = (kind == K_DIR) && dir_st;
   wire        bad = (kind == K_BAD) || ((kind == K_SR_W) && !ok_w) ||
                     ((kind == K_SR_R) && !ok_r) || ((kind == K_MVI_SR) && !ok_i) ||
                     ((kind == K_DIR) && !dir_ld && !dir_st);

   // ------------------------------------------------------------
   // address forming
   // ------------------------------------------------------------
   wire [15:0] page_addr = {regs_q[R_V], b1};
   wire        base_bc = (mode == M_BC);
   wire        base_de = !mode[0] && !mode[3] || (mode == M_DEB);
   wire [15:0] base = base_bc ? pair(regs_q, R_B) :
                      base_de ? pair(regs_q, R_D) : pair(regs_q, R_H);
   // offsets are non-negative: upper byte forced to zero, except the full 16-bit ea_q offset of M_HLEA
   wire [15:0] offs = (mode == M_DEB || mode == M_HLBY) ? {8'h00, b1} :
                      (mode == M_HLA) ? {8'h00, regs_q[R_A]} :
                      (mode == M_HLB) ? {8'h00, regs_q[R_B]} :
                      (mode == M_HLEA) ? ea_q : 16'h0000;
   wire [15:0] acc_to_pair_mem_addr = base + offs;
   wire [15:0] imm_to_pair_mem_addr = pair(regs_q, {op0[1:0], 1'b0});

   wire [15:0] maddr_d = (kind == K_ACC_TO_PAIR_MEM) ? acc_to_pair_mem_addr :
                         (kind == K_IMM_TO_PAIR_MEM) ? imm_to_pair_mem_addr :
                         (kind == K_DIR) ? {b3, b2} : page_addr;
   wire [7:0]  mwdata_d = (kind == K_IMM_TO_PAIR_MEM) ? b1 :
                          (kind == K_IMM_TO_PAGE_SLOT) ? b2 :
                          (kind == K_DIR) ? regs_q[dir_r] :
                          regs_q[R_A];
   wire        mwe_d = issue && ((kind == K_ACC_TO_PAIR_MEM) || (kind == K_IMM_TO_PAIR_MEM) ||
                       (kind == K_IMM_TO_PAGE_SLOT) || (kind == K_ACC_TO_PAGE_SLOT) || st_go);
   wire        mre_d = issue && ((kind == K_PAGE_SLOT_TO_ACC) || ld_go);

   // ------------------------------------------------------------
   // register file write selection
   // ------------------------------------------------------------
   wire [2:0]  src = op0[2:0];
   wire [7:0]  mov_val = (src == T_EAH) ? ea_q[15:8] :
                         (src == T_EAL) ? ea_q[7:0] : regs_q[src];
   wire        res = (ph_q == PH_RESULT) && run;
   wire        wr_imm = issue && ((kind == K_MOV_A_R) || (kind == K_MVI));
   wire        wr_rd = res && (sr_r_go || ld_go || (kind == K_PAGE_SLOT_TO_ACC));
   wire        wr_en = wr_imm || wr_rd;
   wire [2:0]  wr_idx = (kind == K_MVI) ? src : ld_go ? dir_r : R_A;
   wire [7:0]  wr_val = (kind == K_MOV_A_R) ? mov_val :
                        (kind == K_MVI) ? b1 :
                        (kind == K_SR_R) ? sfr_rdata : mem_rdata;

   // auto step only for modes 4..7; other forms keep the base pair
   wire        pw_en = (ph_q == PH_WRITE) && run && (kind == K_ACC_TO_PAIR_MEM) &&
                       (mode inside {[M_DEI:M_HLD]});
   wire [2:0]  pw_hi = mode[0] ? R_H : R_D;
   wire [15:0] pw_val = mode[1] ? base - 16'h0001 : base + 16'h0001;

   // ------------------------------------------------------------
   // phase sequencing
   // ------------------------------------------------------------
   always_comb begin
      ph_d = ph_q;
      case (ph_q)
         PH_FETCH:  if (cnt_q == {2'b00, len}) ph_d = run ? PH_ISSUE : PH_HOLD;
         PH_ISSUE:  ph_d = PH_WRITE;
         PH_WRITE:  ph_d = PH_RESULT;
         PH_RESULT: ph_d = PH_HOLD;
         PH_HOLD:   ph_d = PH_HOLD;
         default:   ph_d = PH_FETCH;
      endcase
      if (fin) ph_d = PH_FETCH;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ph_q <= PH_FETCH;
         cnt_q <= 5'd0;
         pc_q <= RESET_PC;
         fetch_q <= RESET_PC;
      end else begin
         ph_q <= ph_d;
         cnt_q <= fin ? 5'd0 : cnt_q + 5'd1;
         pc_q <= fin ? pc_q + {13'h0000, len} : pc_q;
         fetch_q <= fin ? pc_q + {13'h0000, len} : fetch_q + 16'h0001;
      end
   end

   // byte k of the instruction arrives one cycle after its address
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         for (int k = 0; k < 4; k++) byte_q[k] <= 8'h00;
      end else begin
         for (int k = 0; k < 4; k++) begin
            if (ph_q == PH_FETCH && cnt_q == 5'(k + 1)) byte_q[k] <= prog_data;
         end
      end
   end

   // ------------------------------------------------------------
   // register file and flags
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 8; i++) regs_q[i] <= 8'h00;
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (wr_en && wr_idx == 3'(i)) regs_q[i] <= wr_val;
            if (pw_en && pw_hi == 3'(i)) regs_q[i] <= pw_val[15:8];
            if (pw_en && pw_hi + 3'd1 == 3'(i)) regs_q[i] <= pw_val[7:0];
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ea_q <= 16'h0000;
      end else if (ea_wr_en) begin
         ea_q <= ea_wr_data;
      end
   end

   // a skip request landing on the last state still reaches the next instruction
   wire        mvi_done = fin && run && (kind == K_MVI);
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sk_q <= 1'b0;
         skip_run_q <= 1'b0;
         l1_q <= 1'b0;
         l0_q <= 1'b0;
      end else if (fin) begin
         sk_q <= 1'b0;
         skip_run_q <= sk_q || skip_set;
         l1_q <= mvi_done && (src == R_A);
         l0_q <= mvi_done && (src == R_L);
      end else begin
         sk_q <= sk_q || skip_set;
      end
   end

   // ------------------------------------------------------------
   // memory and special register strobes
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         maddr_q <= 16'h0000;
         mwdata_q <= 8'h00;
         mwe_q <= 1'b0;
         mre_q <= 1'b0;
      end else begin
         mwe_q <= mwe_d;
         mre_q <= mre_d;
         if (mwe_d || mre_d) maddr_q <= maddr_d;
         if (mwe_d) mwdata_q <= mwdata_d;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         scode_q <= 6'h00;
         swdata_q <= 8'h00;
         swe_q <= 1'b0;
         sre_q <= 1'b0;
      end else begin
         swe_q <= issue && (sr_w_go || sr_i_go);
         sre_q <= issue && sr_r_go;
         if (issue && (sr_w_go || sr_r_go)) scode_q <= sr_code;
         if (issue && sr_i_go) scode_q <= {2'b00, imm_code};
         if (issue && sr_w_go) swdata_q <= regs_q[R_A];
         if (issue && sr_i_go) swdata_q <= b2;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         done_q <= 1'b0;
         bad_q <= 1'b0;
      end else begin
         done_q <= fin;
         bad_q <= issue && bad;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign prog_addr = fetch_q;
   assign mem_addr = maddr_q;
   assign mem_wdata = mwdata_q;
   assign mem_we = mwe_q;
   assign mem_re = mre_q;
   assign sfr_code = scode_q;
   assign sfr_wdata = swdata_q;
   assign sfr_we = swe_q;
   assign sfr_re = sre_q;
   for (genvar g = 0; g < 8; g++) begin : g_gpr
      assign gpr[g] = regs_q[g];
   end
   assign wide_accumulator = ea_q;
   assign instr_bypass_flag = sk_q;
   assign acc_chain_flag = l1_q;
   assign low_reg_chain_flag = l0_q;
   assign instr_done = done_q;
   assign bad_op = bad_q;
endmodule

// ==== verification/btx_exec_assertions.sv ====
// btx_exec_assertions: port-level timing and code checks of the byte transfer unit.
// assumes binding onto btx_exec; sees only its ports, one clock domain.
`timescale 1ns/1ns
module btx_exec_assertions #(
   parameter int ADDR_W = 16
) (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       mem_we,
   input  wire logic       mem_re,
   input  wire logic [5:0] sfr_code,
   input  wire logic       sfr_we,
   input  wire logic       sfr_re,
   input  wire logic       instr_bypass_flag,
   input  wire logic       acc_chain_flag,
   input  wire logic       low_reg_chain_flag,
   input  wire logic       instr_done
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // ------------------------------------------------------------
   // instruction length, strobes and flags
   // ------------------------------------------------------------
   a_done_min_gap: assert property (instr_done |=> !instr_done [*3])
      else $error("instruction shorter than four states");
   a_done_max_gap: assert property (instr_done |-> ##[4:17] instr_done)
      else $error("instruction longer than seventeen states");
   a_chain_exclusive: assert property (!(acc_chain_flag && low_reg_chain_flag))
      else $error("both chain flags set");
   a_flags_at_end: assert property (
      ($changed(acc_chain_flag) || $changed(low_reg_chain_flag)) |-> instr_done)
      else $error("chain flag moved outside instruction end");
   a_sfr_write_code: assert property (sfr_we |-> sfr_code inside {
      [6'h00:6'h03], [6'h05:6'h0d], [6'h10:6'h14], 6'h17, 6'h18, 6'h1a, 6'h1b, 6'h28})
      else $error("special write to a code that is not writable");
   a_sfr_read_code: assert property (sfr_re |-> sfr_code inside {
      [6'h00:6'h03], [6'h05:6'h09], 6'h0b, 6'h0d, 6'h19, [6'h20:6'h23]})
      else $error("special read from a code that is not readable");
   a_strobe_alone: assert property ($onehot0({mem_we, mem_re, sfr_we, sfr_re}))
      else $error("two access strobes at once");
   a_store_then_done: assert property (mem_we |-> ##[1:12] instr_done)
      else $error("store not followed by instruction end");
   a_sfr_we_pulse: assert property (sfr_we |=> !sfr_we)
      else $error("special write strobe longer than one cycle");
   c_store: cover property (mem_we);
   c_sfr_read: cover property (sfr_re);
   c_acc_chain: cover property ($rose(acc_chain_flag));
   c_bypass: cover property (instr_bypass_flag);
endmodule
bind btx_exec btx_exec_assertions #(.ADDR_W(ADDR_W)) u_chk (
   .core_clk(core_clk), .rst(rst), .mem_we(mem_we), .mem_re(mem_re),
   .sfr_code(sfr_code), .sfr_we(sfr_we), .sfr_re(sfr_re),
   .instr_bypass_flag(instr_bypass_flag), .acc_chain_flag(acc_chain_flag),
   .low_reg_chain_flag(low_reg_chain_flag), .instr_done(instr_done));

// ==== verification/btx_mem_model.sv ====
// btx_mem_model: program store, data memory and special registers beside btx_exec.
// assumes the bench fills rom, dmem and sfr by hierarchical access before reset ends.
`timescale 1ns/1ns
module btx_mem_model (
   input  wire logic        core_clk,
   input  wire logic [15:0] prog_addr,
   output logic [7:0]       prog_data,
   input  wire logic [15:0] mem_addr,
   input  wire logic [7:0]  mem_wdata,
   input  wire logic        mem_we,
   input  wire logic        mem_re,
   output logic [7:0]       mem_rdata,
   input  wire logic [5:0]  sfr_code,
   input  wire logic [7:0]  sfr_wdata,
   input  wire logic        sfr_we,
   input  wire logic        sfr_re,
   output logic [7:0]       sfr_rdata
);
   logic [7:0] rom [256];
   logic [7:0] dmem [logic [15:0]];
   logic [7:0] sfr [64];
   logic [7:0] noise_q = 8'h5a;
   // read data outside a read cycle keeps changing, so stale values never pass
   always @(posedge core_clk) begin
      noise_q <= noise_q + 8'h3b;
      prog_data <= rom[prog_addr[7:0]];
      mem_rdata <= noise_q;
      sfr_rdata <= ~noise_q;
      if (mem_re)
         mem_rdata <= dmem.exists(mem_addr) ? dmem[mem_addr] : noise_q;
      if (mem_we)
         dmem[mem_addr] = mem_wdata;
      if (sfr_re)
         sfr_rdata <= sfr[sfr_code];
      if (sfr_we)
         sfr[sfr_code] <= sfr_wdata;
   end
endmodule

// ==== verification/btx_exec_tb.sv ====
// btx_exec_tb: runs one transfer program and checks states, flags, registers, memory.
// assumes btx_exec starts fetching at address 0 on the first edge after reset.
`timescale 1ns/1ns
module btx_exec_tb;
   import btx_pkg::*;
   logic core_clk = 1'b0, rst = 1'b1, skip_set = 1'b0, ea_wr_en = 1'b0;
   logic [15:0] ea_wr_data = 16'hc3d2;
   logic [15:0] prog_addr, mem_addr;
   logic [7:0] prog_data, mem_wdata, mem_rdata, sfr_wdata, sfr_rdata;
   logic mem_we, mem_re, sfr_we, sfr_re, instr_done, bad_op;
   logic instr_bypass_flag, acc_chain_flag, low_reg_chain_flag;
   logic [5:0] sfr_code;
   logic [7:0][7:0] gpr;
   logic [15:0] wide_accumulator;
   int num_errors = 0, num_checks = 0, n, nbad = 0;
   logic byp;
   logic [7:0] prog_q [$] = '{8'h6a,8'h55, 8'h69,8'ha0, 8'h6f,8'h40, 8'h6e,8'h20, 8'h68,8'h30,
      8'h6c,8'h10, 8'h6d,8'hfe, 8'h63,8'h77, 8'h3c, 8'h3c, 8'hbf,8'hf0, 8'hbd, 8'h0a,
      8'h4d,8'hc1, 8'h4c,8'hc5, 8'h64,8'h85,8'h99, 8'h70,8'h6b,8'h00,8'h40,
      8'h70,8'h7b,8'h34,8'h12, 8'h71,8'h88,8'h66, 8'h49,8'h77, 8'h01,8'h88,
      8'h69,8'h11, 8'h71,8'h99,8'hab, 8'h08, 8'h09, 8'h0e};
   int st [26] = '{7,7,7,7,7,7,7,10,7,7,13,13,4,10,10,14,17,17,13,10,10,7,10,4,4,4};
   logic [7:0] acc [26] = '{8'h00,8'ha0,8'ha0,8'ha0,8'ha0,8'ha0,8'ha0,8'ha0,8'ha0,8'ha0,
      8'ha0,8'ha0,8'h55,8'h55,8'h3c,8'h3c,8'h3c,8'h3c,8'h3c,8'h3c,8'h66,8'h11,8'h11,
      8'hc3,8'hd2,8'h20};
   logic [15:0] ma [8] = '{16'h3077,16'h10fe,16'h10ff,16'h2130,16'h2095,16'h1234,16'h3088,
      16'h557e};
   logic [7:0] md [8] = '{8'ha0,8'ha0,8'ha0,8'ha0,8'ha0,8'h7e,8'h66,8'h77};
   always #5 core_clk = ~core_clk;
   btx_exec #(.ADDR_W(16)) u_dut (.core_clk(core_clk), .rst(rst), .prog_addr(prog_addr),
      .prog_data(prog_data), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
      .mem_re(mem_re), .mem_rdata(mem_rdata), .sfr_code(sfr_code), .sfr_wdata(sfr_wdata),
      .sfr_we(sfr_we), .sfr_re(sfr_re), .sfr_rdata(sfr_rdata), .skip_set(skip_set),
      .ea_wr_en(ea_wr_en), .ea_wr_data(ea_wr_data), .gpr(gpr),
      .wide_accumulator(wide_accumulator), .instr_bypass_flag(instr_bypass_flag),
      .acc_chain_flag(acc_chain_flag), .low_reg_chain_flag(low_reg_chain_flag),
      .instr_done(instr_done), .bad_op(bad_op));
   btx_mem_model u_mem (.core_clk(core_clk), .prog_addr(prog_addr), .prog_data(prog_data),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re),
      .mem_rdata(mem_rdata), .sfr_code(sfr_code), .sfr_wdata(sfr_wdata), .sfr_we(sfr_we),
      .sfr_re(sfr_re), .sfr_rdata(sfr_rdata));
   // ------------------------------------------------------------
   // compare and closing tasks
   // ------------------------------------------------------------
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_count(input int got, input int exp, input string what);
      num_checks++;
      if (got != exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t %s got %0d exp %0d", $time, what, got, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      foreach (u_mem.rom[i]) u_mem.rom[i] = (i < prog_q.size()) ? prog_q[i] : 8'h0e;
      u_mem.dmem[16'h4000] = 8'h7e;
      u_mem.sfr[5] = 8'h3c;
      repeat (4) @(negedge core_clk);
      rst = 1'b0;
      ea_wr_en = 1'b1;
      @(negedge core_clk);
      ea_wr_en = 1'b0;
      for (int k = 0; k < 26; k++) begin
         n = 0;
         byp = 1'b0;
         do begin
            @(negedge core_clk);
            n++;
            byp = byp | instr_bypass_flag;
            if (bad_op !== 1'b0) nbad++;
         end while (instr_done !== 1'b1 && n < 40);
         if (n >= 40) begin
            num_errors++;
            end_of_test();
         end
         if (k > 0) chk_count(n, st[k], "states");
         chk_byte(gpr[R_A], acc[k], "accumulator");
         chk_byte({6'h0, acc_chain_flag, low_reg_chain_flag},
            {6'h0, k == 1 || k == 21, k == 2}, "chain flags");
         chk_byte({7'h0, byp}, {7'h0, k == 21}, "bypass flag");
         skip_set = (k == 20);
      end
      skip_set = 1'b0;
      $display("test instruction sequence done");
      chk_byte(gpr[R_C], 8'h7e, "direct load target");
      chk_byte(gpr[R_V], 8'h30, "page register");
      chk_byte(gpr[R_D], 8'h11, "pair two high");
      chk_byte(gpr[5], 8'h00, "pair two low");
      chk_byte(gpr[R_H], 8'h20, "pair three high");
      chk_byte(gpr[R_L], 8'h40, "pair three low");
      foreach (ma[i]) chk_byte(u_mem.dmem.exists(ma[i]) ? u_mem.dmem[ma[i]] : 8'hxx, md[i],
         "memory");
      chk_count(u_mem.dmem.exists(16'h3099), 0, "skipped store");
      chk_count(nbad, 0, "bad opcode pulses");
      chk_byte(wide_accumulator[15:8], 8'hc3, "wide accumulator high");
      chk_byte(wide_accumulator[7:0], 8'hd2, "wide accumulator low");
      chk_byte(u_mem.sfr[1], 8'h55, "special write");
      chk_byte(u_mem.sfr[13], 8'h99, "special immediate");
      $display("test memory and register state done");
      end_of_test();
   end
endmodule
